// >>> hw/smsr_top.sv
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module smsr_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic [smsr_pkg::NUM_IN-1:0] tooth_in,
  input wire logic [smsr_pkg::NUM_IN-1:0] level_in,
  input wire logic [smsr_pkg::NUM_IN-1:0] disc_in,
  input wire logic [smsr_pkg::NUM_IN-1:0] overacc_in,
  input wire logic [smsr_pkg::NUM_IN-1:0] overspd_in,
  input wire logic [smsr_pkg::NUM_OUT*smsr_pkg::COILS-1:0] coil_vfield_in,
  input wire logic [smsr_pkg::NUM_OUT*smsr_pkg::COILS-1:0] coil_current_in,
  input wire logic [smsr_pkg::NUM_OUT*smsr_pkg::COILS-1:0] coil_load_in,
  input wire logic [smsr_pkg::NUM_OUT-1:0] trip_cond_in,
  output logic [smsr_pkg::NUM_OUT-1:0] coil_drive
);
  import smsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {REG_CTRL, REG_INST, REG_IMSK, REG_DISC, REG_TEST, REG_CHAN, REG_NONE} smsr_reg_t;
  typedef struct packed {
    logic [NUM_IN-1:0] t1;
    logic [NUM_IN-1:0] t2;
    logic [NUM_IN-1:0] tp;
    logic [NUM_IN-1:0] l1;
    logic [NUM_IN-1:0] l2;
    logic [NUM_IN-1:0] d1;
    logic [NUM_IN-1:0] d2;
    logic [NUM_IN-1:0] a1;
    logic [NUM_IN-1:0] a2;
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_OUT*COILS-1:0] v1;
    logic [NUM_OUT*COILS-1:0] v2;
    logic [NUM_OUT*COILS-1:0] c1;
    logic [NUM_OUT*COILS-1:0] c2;
    logic [NUM_OUT*COILS-1:0] ld1;
    logic [NUM_OUT*COILS-1:0] ld2;
    logic [NUM_OUT-1:0] tc1;
    logic [NUM_OUT-1:0] tc2;
    logic [NUM_IN-1:0][TW-1:0] quiet;
    logic [NUM_IN-1:0] seen;
    logic [NUM_IN-1:0][TW-1:0] dcnt;
    logic [NUM_IN-1:0] dflt;
    logic [NUM_OUT-1:0] trip;
    logic [NUM_OUT-1:0] drv;
    logic [NUM_OUT-1:0] rst_prev;
    logic [NUM_GRP-1:0] test;
    logic [NUM_GRP-1:0][TW-1:0] tcnt;
    logic [TW-1:0] disc_lim;
    logic [TW-1:0] test_lim;
    logic [NUM_OUT-1:0] trip_rst;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic [NUM_IN+NUM_OUT+NUM_OUT+NUM_GRP-1:0][2:0] code;
    logic ap_v;
    logic ap_w;
    logic [31:0] ap_a;
    logic [31:0] rdata;
    logic irq;
  } smsr_state_t;

  smsr_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Summary of four coils of one output channel
  function automatic logic [2:0] coil_sum(input logic [COILS-1:0] v, input logic [COILS-1:0] c,
                                          input logic [COILS-1:0] ld, input logic drv);
    logic [2:0] r;
    r = CO_FAULT;
    if (!drv && (|c))
    begin
      r = CO_FIELDFLT; // R9
    end
    else if (~|v)
    begin
      r = CO_NOFIELD; // R8
    end
    else if (!(&v))
    begin
      r = CO_FAULT; // R9
    end
    else if (!drv)
    begin
      r = CO_DEENERG; // R8
    end
    else if (~|ld)
    begin
      r = CO_LOADOPEN; // R8
    end
    else if ((&ld) && (&c))
    begin
      r = CO_ENERG; // R9
    end
    return r; // R10
  endfunction

  // One input channel's state code, priority fault, discrepancy, trips, quiet
  function automatic logic [2:0] in_code(input logic flt, input logic dsc, input logic spd,
                                         input logic acc, input logic seen, input logic lvl);
    logic [2:0] r;
    r = IN_INVALID;
    if (flt)
    begin
      r = IN_FAULT; // R6
    end
    else if (dsc)
    begin
      r = IN_DISC; // R2 R6
    end
    else if (spd)
    begin
      r = IN_OVERSPD; // R3
    end
    else if (acc)
    begin
      r = IN_OVERACC; // R3
    end
    else if (seen)
    begin
      r = IN_NORMAL; // R5
    end
    else
    begin
      r = lvl ? IN_HIGH : IN_LOW; // R2 R4
    end
    return r;
  endfunction

  // Register decode shared by the write and read paths
  function automatic smsr_reg_t reg_of(input logic [31:0] a);
    smsr_reg_t r;
    r = REG_NONE;
    case (a)
      A_CTRL:
        r = REG_CTRL;
      A_INST:
        r = REG_INST;
      A_IMSK:
        r = REG_IMSK;
      A_DISC:
        r = REG_DISC;
      A_TEST:
        r = REG_TEST;
      default:
      begin
        if (a >= A_CH1 && a <= A_CH24 && a[1:0] == 2'h0)
          r = REG_CHAN;
        else
          r = REG_NONE;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [IRQ_W-1:0] ev;
    logic [NUM_OUT-1:0] rise;
    logic [NUM_GRP-1:0] tend;
    logic [6:0] idx;
    logic do_w;
    smsr_reg_t wsel;
    smsr_reg_t rsel;
    s_d = s_q;
    ev = '0;
    rise = '0;
    do_w = 1'b0;
    wsel = REG_NONE;
    rsel = REG_NONE;
    tend = '0;
    idx = '0;
    // Input synchronisers
    s_d.t1 = tooth_in;
    s_d.t2 = s_q.t1;
    s_d.tp = s_q.t2;
    s_d.l1 = level_in;
    s_d.l2 = s_q.l1;
    s_d.d1 = disc_in;
    s_d.d2 = s_q.d1;
    s_d.a1 = overacc_in;
    s_d.a2 = s_q.a1;
    s_d.s1 = overspd_in;
    s_d.s2 = s_q.s1;
    s_d.v1 = coil_vfield_in;
    s_d.v2 = s_q.v1;
    s_d.c1 = coil_current_in;
    s_d.c2 = s_q.c1;
    s_d.ld1 = coil_load_in;
    s_d.ld2 = s_q.ld1;
    s_d.tc1 = trip_cond_in;
    s_d.tc2 = s_q.tc1;
    // Tooth watchdog and discrepancy escalation per input
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (s_q.t2[i] && !s_q.tp[i])
      begin
        s_d.quiet[i] = '0; // R5
        s_d.seen[i] = 1'b1; // R5
      end
      else if (64'(s_q.quiet[i]) >= NO_TOOTH_CYC - 64'd1)
      begin
        if (s_q.seen[i])
          ev[0] = 1'b1;
        s_d.seen[i] = 1'b0; // R4
      end
      else
        s_d.quiet[i] = s_q.quiet[i] + TW'(1); // R4
      if (!s_q.d2[i])
      begin
        s_d.dcnt[i] = '0;
        s_d.dflt[i] = 1'b0;
      end
      else if (s_q.dcnt[i] >= s_q.disc_lim)
      begin
        if (!s_q.dflt[i])
          ev[1] = 1'b1;
        s_d.dflt[i] = 1'b1; // R6
      end
      else
        s_d.dcnt[i] = s_q.dcnt[i] + TW'(1); // R6
      s_d.code[i] = in_code(s_q.dflt[i], s_q.d2[i], s_q.s2[i], s_q.a2[i], s_q.seen[i], s_q.l2[i]); // R1
    end
    // Trip latches; reset acts on rising edge only when condition is gone
    rise = s_q.trip_rst & ~s_q.rst_prev;
    s_d.rst_prev = s_q.trip_rst;
    for (int o = 0; o < NUM_OUT; o++)
    begin
      if (s_q.tc2[o])
      begin
        if (!s_q.trip[o])
          ev[2] = 1'b1;
        s_d.trip[o] = 1'b1;
      end
      else if (rise[o])
        s_d.trip[o] = 1'b0; // R14
      s_d.code[NUM_IN+o] = coil_sum(s_q.v2[o*COILS +: COILS], s_q.c2[o*COILS +: COILS],
                                    s_q.ld2[o*COILS +: COILS], ~s_q.trip[o]); // R7
      s_d.code[NUM_IN+NUM_OUT+o] = s_q.trip[o] ? TRIP_YES : TRIP_NO; // R11
    end
    s_d.drv = ~s_d.trip; // R11
    // Over-speed test per group
    for (int g = 0; g < NUM_GRP; g++)
    begin
      if (s_q.test[g])
      begin
        if (s_q.tcnt[g] >= s_q.test_lim || s_q.trip[2*g] || rise[2*g])
        begin
          s_d.test[g] = 1'b0; // R13
          tend[g] = 1'b1;
        end
        else
          s_d.tcnt[g] = s_q.tcnt[g] + TW'(1);
      end
      s_d.code[NUM_IN+2*NUM_OUT+g] = s_q.test[g] ? TEST_ON : TEST_OFF; // R12
    end
    if (|tend)
      ev[3] = 1'b1;
    // AHB-Lite data phase for writes
    do_w = s_q.ap_v && s_q.ap_w;
    wsel = do_w ? reg_of(s_q.ap_a) : REG_NONE;
    case (wsel)
      REG_CTRL:
        s_d.trip_rst = hwdata[NUM_OUT-1:0];
      REG_IMSK:
        s_d.imsk = hwdata[IRQ_W-1:0];
      REG_DISC:
        s_d.disc_lim = hwdata;
      REG_TEST:
      begin
        for (int g = 0; g < NUM_GRP; g++)
          if (hwdata[g] && !s_q.test[g] && !s_q.trip[2*g] && !tend[g])
          begin
            s_d.test[g] = 1'b1;
            s_d.tcnt[g] = '0;
          end
      end
      default:
        s_d.trip_rst = s_q.trip_rst;
    endcase
    s_d.ist = s_q.ist & ~((wsel == REG_INST) ? hwdata[IRQ_W-1:0] : '0);
    s_d.ist = s_d.ist | ev;
    s_d.irq = |(s_d.ist & s_q.imsk);
    // Address phase capture and read data
    s_d.ap_v = hsel && hready && htrans[1];
    s_d.ap_w = hwrite;
    s_d.ap_a = haddr;
    s_d.rdata = '0;
    rsel = (s_d.ap_v && !hwrite) ? reg_of(haddr) : REG_NONE;
    case (rsel)
      REG_CTRL:
        s_d.rdata = 32'(s_q.trip_rst);
      REG_INST:
        s_d.rdata = 32'(s_q.ist);
      REG_IMSK:
        s_d.rdata = 32'(s_q.imsk);
      REG_DISC:
        s_d.rdata = s_q.disc_lim;
      REG_TEST:
        s_d.rdata = 32'(s_q.test);
      REG_CHAN:
      begin
        idx = 7'((haddr - A_CH1) >> 2);
        s_d.rdata = 32'(s_q.code[idx]); // R15
      end
      default:
        s_d.rdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.disc_lim <= TW'(DISC_DEF_CYC);
      s_q.test_lim <= TW'(TEST_DEF_CYC);
      s_q.drv <= '1;
    end
    else
      s_q <= s_d;
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = s_q.irq;
  assign coil_drive = s_q.drv;
endmodule // smsr_top
`default_nettype wire

// >>> include/smsr_pkg.sv
// Behaviour
// R1: Nine sensor input state codes, three per group, on channels 1 to 9.
// R2: Input codes: 0 invalid, 1 steady low, 2 steady high, 3 discrepant.
// R3: Input codes: 4 normal, 5 over-acceleration, 6 over-speed, 7 faulted or unknown.
// R4: Steady low or high reported only after three seconds without a tooth; the code reports it straight after reset, until the first tooth.
// R5: A tooth in every three-second interval gives code 4, normal speed.
// R6: Discrepant input reports 3; past the duration limit it reports 7.
// R7: Six coil drive state codes, per group speed and acceleration, channels 10 to 15.
// R8: Coil codes: 0 invalid, 1 no field voltage, 2 de-energised, 3 load open.
// R9: Coil codes: 4 energised, 5 unused, 6 field fault, 7 faulted or unknown.
// R10: Each coil code summarises that channel's four coils, never single coils.
// R11: Six trip states on channels 16 to 21: 2 tripped, 4 not tripped.
// R12: Per-group over-speed test state on 22 to 24: 0 idle, 1 active.
// R13: Test indication ends on timeout, actual trip or reset, then reports 0.
// R14: Latched trip clears only on reset rising edge, and not while condition holds.
// R15: Each code sits in an unsigned field at least three bits wide, upper bits zero.
package smsr_pkg;
  localparam int unsigned NUM_IN = 9;
  localparam int unsigned NUM_OUT = 6;
  localparam int unsigned NUM_GRP = 3;
  localparam int unsigned COILS = 4;
  localparam int unsigned CW = 3;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NO_TOOTH_S = 3;
  localparam longint unsigned NO_TOOTH_CYC = longint'(NO_TOOTH_S) * longint'(CLK_HZ);
  localparam int unsigned TW = 32;
  localparam int unsigned DISC_DEF_CYC = 100_000_000;
  localparam int unsigned TEST_DEF_CYC = 1_000_000_000;
  localparam logic [2:0] IN_INVALID = 3'h0;
  localparam logic [2:0] IN_LOW = 3'h1;
  localparam logic [2:0] IN_HIGH = 3'h2;
  localparam logic [2:0] IN_DISC = 3'h3;
  localparam logic [2:0] IN_NORMAL = 3'h4;
  localparam logic [2:0] IN_OVERACC = 3'h5;
  localparam logic [2:0] IN_OVERSPD = 3'h6;
  localparam logic [2:0] IN_FAULT = 3'h7;
  localparam logic [2:0] CO_INVALID = 3'h0;
  localparam logic [2:0] CO_NOFIELD = 3'h1;
  localparam logic [2:0] CO_DEENERG = 3'h2;
  localparam logic [2:0] CO_LOADOPEN = 3'h3;
  localparam logic [2:0] CO_ENERG = 3'h4;
  localparam logic [2:0] CO_FIELDFLT = 3'h6;
  localparam logic [2:0] CO_FAULT = 3'h7;
  localparam logic [2:0] TRIP_YES = 3'h2;
  localparam logic [2:0] TRIP_NO = 3'h4;
  localparam logic [2:0] TEST_OFF = 3'h0;
  localparam logic [2:0] TEST_ON = 3'h1;
  localparam logic [31:0] A_CTRL = 32'h0000_0000;
  localparam logic [31:0] A_INST = 32'h0000_0004;
  localparam logic [31:0] A_IMSK = 32'h0000_0008;
  localparam logic [31:0] A_DISC = 32'h0000_000c;
  localparam logic [31:0] A_TEST = 32'h0000_0010;
  localparam logic [31:0] A_CH1 = 32'h0000_0100;
  localparam logic [31:0] A_CH24 = 32'h0000_015c;
  localparam int unsigned IRQ_W = 4;
endpackage

// >>> test/smsr_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module smsr_top_properties
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic [smsr_pkg::NUM_OUT-1:0] trip_cond_in,
  input wire logic [smsr_pkg::NUM_OUT-1:0] coil_drive
);
  import smsr_pkg::*;
  logic rd_q;
  logic map_q;
  logic ch_q;
  logic [3:0] age_q;
  wire logic acc = hsel && hready && htrans[1];
  wire logic chn = (haddr >= A_CH1) && (haddr <= A_CH24);
  // Cycles since the last accepted write, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      map_q <= 1'b0;
      ch_q <= 1'b0;
      age_q <= 4'hf;
    end
    else
    begin
      rd_q <= acc && !hwrite;
      ch_q <= chn;
      map_q <= chn || (haddr <= A_TEST);
      age_q <= (acc && hwrite) ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_held;
    trip_cond_in[0] [*3];
  endsequence
  property p_ready; hreadyout && !hresp; endproperty
  property p_idle; !rd_q |-> hrdata == 32'h0; endproperty
  property p_unmap; rd_q && !map_q |-> hrdata == 32'h0; endproperty
  property p_width; rd_q && ch_q |-> hrdata[31:3] == 29'h0; endproperty
  property p_cut; s_held |-> ##[0:3] !coil_drive[0]; endproperty
  property p_hold; trip_cond_in[0] [*6] |-> !coil_drive[0]; endproperty
  property p_rise; |(coil_drive & ~$past(coil_drive)) |-> age_q <= 4'h8; endproperty
  property p_irq; $fell(irq) |-> age_q <= 4'h4; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or error");
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_width: assert property (p_width) else $error("code upper bits set");
  a_cut: assert property (p_cut) else $error("trip did not cut drive");
  a_hold: assert property (p_hold) else $error("drive while trip holds");
  a_rise: assert property (p_rise) else $error("drive restored without command");
  a_irq: assert property (p_irq) else $error("irq fell without write");
endmodule // smsr_top_properties
bind smsr_top smsr_top_properties u_smsr_top_properties
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
  .trip_cond_in(trip_cond_in), .coil_drive(coil_drive)
);
`default_nettype wire

// >>> test/smsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module smsr_host
(
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Waits for hready high at a rising edge and takes hrdata at that edge
  task automatic wt(output logic [31:0] d, output bit to);
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    to = n >= 100;
    d = hrdata;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] d, output bit to);
    bit t1;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt(d, t1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt(d, to);
    to = to | t1;
  endtask
endmodule // smsr_host
`default_nettype wire

// >>> test/speed_monitor_state_report_tb.sv
`timescale 1ns/10ps
`default_nettype none
module speed_monitor_state_report_tb;
  import smsr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] tooth, disc, oacc, ospd;
  logic [23:0] vf, cur, ld;
  logic [5:0] trip, drv;
  int errors, checks;
  smsr_top u_smsr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .tooth_in(tooth), .level_in(9'h0), .disc_in(disc),
    .overacc_in(oacc), .overspd_in(ospd), .coil_vfield_in(vf), .coil_current_in(cur), .coil_load_in(ld),
    .trip_cond_in(trip), .coil_drive(drv));
  smsr_host u_smsr_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // A tooth every other cycle keeps all inputs in the normal range
  always @(posedge hclk) tooth <= ~tooth;
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    bit to;
    u_smsr_host.xfer(w, a, wd, d, to);
    if (to)
    begin
      errors++;
      test_done();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    acc(1'b1, a, d, x);
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    acc(1'b0, a, 32'h0, x);
    chk(n, x, e);
  endtask
  task automatic chan(input int c, input logic [2:0] e);
    rdc($sformatf("ch%0d", c), A_CH1 + 32'(4 * (c - 1)), {29'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic pin(input string n, input logic s, input logic e);
    @(negedge hclk);
    chk(n, {31'h0, s}, {31'h0, e});
    @(posedge hclk);
  endtask
  task automatic s_inputs;
    for (int c = 1; c <= 9; c++) chan(c, IN_NORMAL);
    wr(A_DISC, 32'h28);
    oacc[1] <= 1'b1;
    oacc[2] <= 1'b1;
    ospd[2] <= 1'b1;
    disc[4:3] <= 2'h3;
    cyc(10);
    chan(2, IN_OVERACC);
    chan(3, IN_OVERSPD);
    chan(4, IN_DISC);
    cyc(60);
    chan(5, IN_FAULT);
    chan(6, IN_NORMAL);
  endtask
  task automatic coil(input logic [3:0] v, l, c, input logic [2:0] e);
    vf[7:4] <= v;
    ld[7:4] <= l;
    cur[7:4] <= c;
    cyc(8);
    chan(11, e);
  endtask
  task automatic s_coil;
    coil(4'hf, 4'hf, 4'hf, CO_ENERG);
    coil(4'h0, 4'hf, 4'h0, CO_NOFIELD);
    coil(4'h3, 4'hf, 4'hf, CO_FAULT);
    coil(4'hf, 4'h0, 4'h0, CO_LOADOPEN);
    coil(4'hf, 4'hf, 4'h0, CO_FAULT);
    trip[1] <= 1'b1;
    coil(4'hf, 4'hf, 4'h0, CO_DEENERG);
    coil(4'hf, 4'hf, 4'hf, CO_FIELDFLT);
    pin("drv1", drv[1], 1'b0);
    trip[1] <= 1'b0;
  endtask
  task automatic s_trip;
    wr(A_TEST, 32'h1);
    cyc(4);
    chan(22, TEST_ON);
    trip[0] <= 1'b1;
    cyc(8);
    chan(16, TRIP_YES);
    chan(18, TRIP_NO);
    chan(22, TEST_OFF);
    wr(A_CTRL, 32'h1);
    cyc(6);
    chan(16, TRIP_YES);
    trip[0] <= 1'b0;
    wr(A_CTRL, 32'h0);
    cyc(6);
    chan(16, TRIP_YES);
    wr(A_CTRL, 32'h1);
    cyc(6);
    chan(16, TRIP_NO);
    pin("drv0", drv[0], 1'b1);
    wr(A_TEST, 32'h2);
    cyc(4);
    chan(23, TEST_ON);
    wr(A_CTRL, 32'h5);
    cyc(6);
    chan(23, TEST_OFF);
  endtask
  task automatic s_irq;
    pin("irq", irq, 1'b0);
    wr(A_IMSK, 32'h4);
    cyc(3);
    pin("irq", irq, 1'b1);
    rdc("stat", A_INST, 32'he);
    wr(A_INST, 32'h4);
    cyc(3);
    pin("irq", irq, 1'b0);
    rdc("stat", A_INST, 32'ha);
    wr(32'h200, 32'hffff_ffff);
    rdc("hole", 32'h200, 32'h0);
  endtask
  initial
  begin
    hresetn = 1'b0;
    tooth = 9'h0;
    disc = 9'h0;
    oacc = 9'h0;
    ospd = 9'h0;
    vf = 24'hff_ffff;
    ld = 24'hff_ffff;
    cur = 24'hff_ffff;
    trip = 6'h0;
    errors = 0;
    checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(8);
    s_inputs();
    s_coil();
    s_trip();
    s_irq();
    test_done();
  end
endmodule // speed_monitor_state_report_tb
`default_nettype wire
